/* File: logic/srt_rtc.sv */
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
module srt_rtc #(
  // arbitrary value, any non-zero code will do
  parameter logic [15:0] UNLOCK_CODE = 16'h5A5A
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic xtal_in,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic pwr_sleep,
  input wire logic pwr_off,
  output logic alarm_irq,
  output logic wake_req,
  output logic on_req
);
  import srt_pkg::*;

  // maximal-length shift; a non-zero seed never reaches zero
  function automatic logic [15:0] lfsr_step(input logic [15:0] v);
    lfsr_step = v[0] ? ((v >> 1) ^ LFSR_TAPS) : (v >> 1);
  endfunction

  // one write decode shared by every register
  function automatic logic wr_hit(input logic wr, input logic [15:0] addr,
    input logic [15:0] off);
    wr_hit = wr && (addr == off);
  endfunction

  logic osc_rise, sec_tick;

  // crystal level is asynchronous, filtered before any use
  srt_sync3 u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in(xtal_in),
    .rise(osc_rise)
  );

  logic [TRIM_W-1:0] trim_r, trim_nxt;

  // trim reaches the divider only through the locked register
  srt_prescale u_pre (
    .core_clk(core_clk),
    .reset(reset),
    .osc_rise(osc_rise),
    .trim(trim_r),
    .sec_tick(sec_tick)
  );

  // update window state, read by the write decode
  logic [3:0] upd_cnt_r, upd_cnt_nxt;
  logic [11:0] win_r, win_nxt;
  logic win_act_r, win_act_nxt, win_done;

  // write decode
  logic wr_time_hi, wr_time_lo, wr_alm_hi, wr_alm_lo;
  logic wr_ctrl, wr_trim, wr_sec, time_wr, time_ok;
  always_comb begin
    wr_time_hi = wr_hit(reg_wr, reg_addr, OFF_TIME_HI);
    wr_time_lo = wr_hit(reg_wr, reg_addr, OFF_TIME_LO);
    wr_alm_hi = wr_hit(reg_wr, reg_addr, OFF_ALM_HI);
    wr_alm_lo = wr_hit(reg_wr, reg_addr, OFF_ALM_LO);
    wr_ctrl = wr_hit(reg_wr, reg_addr, OFF_CTRL);
    wr_trim = wr_hit(reg_wr, reg_addr, OFF_TRIM);
    wr_sec = wr_hit(reg_wr, reg_addr, OFF_SECURITY);
    time_wr = wr_time_hi | wr_time_lo;
    // hour ending this cycle frees the count for a write
    win_done = win_act_r && sec_tick && (win_r == 12'h001);
    time_ok = time_wr && (win_done || (upd_cnt_r < MAX_UPDATES));
  end

  // seconds count, validity, tamper counter
  logic [31:0] secs_r, secs_nxt;
  logic valid_r, valid_nxt;
  logic [15:0] tamper_r, tamper_nxt, lfsr_r, lfsr_nxt;
  always_comb begin
    secs_nxt = secs_r;
    // a tick and a write together: the written half wins
    // free-running count
    if (sec_tick) begin
      secs_nxt = secs_r + 32'h0000_0001;
    end
    if (time_ok && wr_time_hi) begin
      secs_nxt[31:16] = reg_wdata;
    end
    if (time_ok && wr_time_lo) begin
      secs_nxt[15:0] = reg_wdata;
    end
    valid_nxt = valid_r | time_ok;
    // keeps stepping so the sampled value depends on write timing
    lfsr_nxt = lfsr_step(lfsr_r);
    tamper_nxt = tamper_r;
    // never repeats the value it replaces, so every write shows
    // tamper value refresh
    if (time_ok) begin
      tamper_nxt = (lfsr_r == tamper_r) ? lfsr_nxt : lfsr_r;
    end
  end

  always_ff @(posedge core_clk) begin
    // reset stands for power-up from no power
    // power-up default
    if (reset) begin
      secs_r <= SECS_RESET;
      valid_r <= 1'b0;
      tamper_r <= TAMPER_RESET;
      lfsr_r <= LFSR_SEED;
    end else begin
      secs_r <= secs_nxt;
      valid_r <= valid_nxt;
      tamper_r <= tamper_nxt;
      lfsr_r <= lfsr_nxt;
    end
  end

  // update window, opened by the first accepted write, not on a grid
  always_comb begin
    upd_cnt_nxt = upd_cnt_r;
    win_nxt = win_r;
    win_act_nxt = win_act_r;
    if (win_act_r && sec_tick) begin
      if (win_r == 12'h001) begin
        win_act_nxt = 1'b0;
        upd_cnt_nxt = 4'h0;
        win_nxt = 12'h000;
      end else begin
        win_nxt = win_r - 12'h001;
      end
    end
    // a write in the closing cycle starts the next hour
    // count accepted updates
    if (time_ok) begin
      if (!win_act_nxt) begin
        win_act_nxt = 1'b1;
        win_nxt = HOUR_TICKS;
        upd_cnt_nxt = 4'h1;
      end else begin
        upd_cnt_nxt = upd_cnt_nxt + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      upd_cnt_r <= 4'h0;
      win_r <= 12'h000;
      win_act_r <= 1'b0;
    end else begin
      upd_cnt_r <= upd_cnt_nxt;
      win_r <= win_nxt;
      win_act_r <= win_act_nxt;
    end
  end

  // alarm, control, trim and lock
  logic [31:0] alm_r, alm_nxt;
  logic alm_en_r, alm_en_nxt, unlock_r, unlock_nxt;
  always_comb begin
    alm_nxt = alm_r;
    alm_en_nxt = alm_en_r;
    trim_nxt = trim_r;
    unlock_nxt = unlock_r;
    if (wr_alm_hi) begin
      alm_nxt[31:16] = reg_wdata;
    end
    if (wr_alm_lo) begin
      alm_nxt[15:0] = reg_wdata;
    end
    // only the enable bit is writable; status bits are read-only
    if (wr_ctrl) begin
      alm_en_nxt = reg_wdata[CTRL_ALM_EN_BIT];
    end
    // any other code locks again, so a stray write cannot unlock
    // key lock
    if (wr_sec) begin
      unlock_nxt = (reg_wdata == UNLOCK_CODE);
    end
    if (wr_trim && unlock_r) begin
      trim_nxt = reg_wdata[TRIM_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      alm_r <= ALM_RESET;
      alm_en_r <= 1'b0;
      trim_r <= TRIM_RESET;
      unlock_r <= 1'b0;
    end else begin
      alm_r <= alm_nxt;
      alm_en_r <= alm_en_nxt;
      trim_r <= trim_nxt;
      unlock_r <= unlock_nxt;
    end
  end

  // writes while busy are not refused; the host has to poll
  // sync busy: held for two oscillator edges after an update
  logic busy_r, busy_nxt, clk_reg_wr;
  logic [1:0] busy_cnt_r, busy_cnt_nxt;
  always_comb begin
    clk_reg_wr = time_ok | wr_alm_hi | wr_alm_lo | wr_ctrl
      | (wr_trim & unlock_r);
    busy_nxt = busy_r;
    busy_cnt_nxt = busy_cnt_r;
    // a fresh write restarts the count
    // busy while settling
    if (clk_reg_wr) begin
      busy_nxt = 1'b1;
      busy_cnt_nxt = SYNC_OSC_EDGES;
    end else if (busy_r && osc_rise) begin
      busy_cnt_nxt = busy_cnt_r - 2'h1;
      if (busy_cnt_r == 2'h1) begin
        busy_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      busy_r <= 1'b0;
      busy_cnt_r <= 2'h0;
    end else begin
      busy_r <= busy_nxt;
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  // alarm event and power requests
  logic match_now, match_r, irq_nxt, wake_nxt, on_nxt;
  logic irq_r, wake_r, on_r;
  always_comb begin
    match_now = alm_en_r && (secs_r == alm_r);
    irq_nxt = match_now & ~match_r;
    // power state taken in the cycle the match begins
    // state-dependent request
    wake_nxt = irq_nxt & pwr_sleep;
    on_nxt = irq_nxt & pwr_off & ~pwr_sleep;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      match_r <= 1'b0;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
      on_r <= 1'b0;
    end else begin
      match_r <= match_now;
      irq_r <= irq_nxt;
      wake_r <= wake_nxt;
      on_r <= on_nxt;
    end
  end

  // read port, unmapped offsets read zero
  // registered: data stand only in the cycle after the strobe
  logic [15:0] rdata_r, rdata_nxt;
  always_comb begin
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        OFF_TAMPER: rdata_nxt = tamper_r;
        OFF_TIME_HI: rdata_nxt = secs_r[31:16];
        OFF_TIME_LO: rdata_nxt = secs_r[15:0];
        OFF_ALM_HI: rdata_nxt = alm_r[31:16];
        OFF_ALM_LO: rdata_nxt = alm_r[15:0];
        OFF_CTRL: begin
          rdata_nxt[CTRL_ALM_EN_BIT] = alm_en_r;
          rdata_nxt[CTRL_VALID_BIT] = valid_r;
          rdata_nxt[CTRL_BUSY_BIT] = busy_r;
        end
        OFF_TRIM: rdata_nxt[TRIM_W-1:0] = trim_r;
        OFF_SECURITY: rdata_nxt[0] = unlock_r;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign alarm_irq = irq_r;
  assign wake_req = wake_r;
  assign on_req = on_r;
endmodule

/* File: logic/srt_pkg.sv */
// How it works
// - 32-bit seconds count advances once per second from the 32.768 kHz source
// - seconds count always runs; nothing can stop it
// - seconds count is read and written as two 16-bit registers 4021h/4022h
// - reset from no power loads the seconds count with its default
// - writing either seconds half sets the time-valid status bit
// - sync-busy status bit is high while a clock register update settles
// - each accepted seconds write changes the write-tamper counter
// - at most 8 time updates per hour; extra writes are silently dropped
// - alarm time is held in two 16-bit registers 4023h/4024h
// - alarm enabled and seconds equal alarm time raises the alarm event
// - alarm in sleep requests wake; alarm in off requests power-on
// - trim is 10-bit two's complement, MSB weighs -8 Hz
// - trim changes only accepted after the unlock code is written
// - 4021h holds the upper seconds half, 4022h the lower half
// - write-tamper counter takes a new pseudo-random value per accepted seconds write
package srt_pkg;
  localparam logic [15:0] OFF_TAMPER = 16'h4020;
  localparam logic [15:0] OFF_TIME_HI = 16'h4021;
  localparam logic [15:0] OFF_TIME_LO = 16'h4022;
  localparam logic [15:0] OFF_ALM_HI = 16'h4023;
  localparam logic [15:0] OFF_ALM_LO = 16'h4024;
  localparam logic [15:0] OFF_CTRL = 16'h4025;
  localparam logic [15:0] OFF_TRIM = 16'h4026;
  localparam logic [15:0] OFF_SECURITY = 16'h4027;

  localparam int CTRL_ALM_EN_BIT = 0;
  localparam int CTRL_VALID_BIT = 1;
  localparam int CTRL_BUSY_BIT = 2;
  localparam int TRIM_W = 10;
  localparam int TRIM_FRAC_BITS = 6;

  localparam logic [31:0] SECS_RESET = 32'h0000_0000;
  localparam logic [31:0] ALM_RESET = 32'h0000_0000;
  localparam logic [15:0] TAMPER_RESET = 16'h0000;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;
  localparam logic [9:0] TRIM_RESET = 10'h000;

  localparam int OSC_NOM_HZ = 32768;
  localparam int ACC_W = 23;
  localparam logic [ACC_W-1:0] ACC_STEP = 23'h00_0040;
  localparam logic [ACC_W-1:0] ACC_NOM =
    ACC_W'(OSC_NOM_HZ * (1 << TRIM_FRAC_BITS));
  localparam int HOUR_S = 3600;
  localparam logic [11:0] HOUR_TICKS = 12'(HOUR_S);
  localparam logic [3:0] MAX_UPDATES = 4'h8;
  localparam logic [1:0] SYNC_OSC_EDGES = 2'h2;
endpackage

/* File: logic/srt_sync3.sv */
`timescale 1ns/1ns
module srt_sync3 (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic async_in,
  output logic rise
);
  logic s1_r, s2_r, s3_r, lvl_r, rise_r;
  logic lvl_nxt, rise_nxt;

  // level only moves once the two later stages agree
  always_comb begin
    lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
    rise_nxt = lvl_nxt & ~lvl_r;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      lvl_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
      rise_r <= rise_nxt;
    end
  end

  assign rise = rise_r;
endmodule

/* File: logic/srt_prescale.sv */
`timescale 1ns/1ns
module srt_prescale (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic osc_rise,
  input wire logic [srt_pkg::TRIM_W-1:0] trim,
  output logic sec_tick
);
  import srt_pkg::*;
  logic [ACC_W-1:0] acc_r, acc_nxt, target, sum;
  logic tick_r, tick_nxt;

  // fractional divider
  // each osc edge adds 64; a second lasts 32768*64 + trim sixty-fourths
  always_comb begin
    target = ACC_NOM + {{(ACC_W - TRIM_W){trim[TRIM_W-1]}}, trim};
    sum = acc_r + ACC_STEP;
    acc_nxt = acc_r;
    tick_nxt = 1'b0;
    if (osc_rise) begin
      if (sum >= target) begin
        acc_nxt = sum - target;
        tick_nxt = 1'b1;
      end else begin
        acc_nxt = sum;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      acc_r <= '0;
      tick_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign sec_tick = tick_r;
endmodule

/* File: testbench/srt_rtc_asserts.sv */
`timescale 1ns/1ns
module srt_rtc_chk (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic pwr_sleep,
  input wire logic pwr_off,
  input wire logic alarm_irq,
  input wire logic wake_req,
  input wire logic on_req
);
  logic [15:0] ahi_r, ahi_nxt, alo_r, alo_nxt;
  logic en_r, en_nxt;
  // shadow of host-written alarm state
  always_comb begin
    ahi_nxt = (reg_wr && reg_addr == 16'h4023) ? reg_wdata : ahi_r;
    alo_nxt = (reg_wr && reg_addr == 16'h4024) ? reg_wdata : alo_r;
    en_nxt = (reg_wr && reg_addr == 16'h4025) ? reg_wdata[0] : en_r;
  end
  always_ff @(posedge core_clk) begin
    ahi_r <= reset ? 16'h0000 : ahi_nxt;
    alo_r <= reset ? 16'h0000 : alo_nxt;
    en_r <= reset ? 1'b0 : en_nxt;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_rdata_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  chk_alarm_hi_rb:
    assert property ($past(reg_rd) && $past(reg_addr) == 16'h4023
      |-> reg_rdata == $past(ahi_r)) else $error("alarm high readback");
  chk_alarm_lo_rb:
    assert property ($past(reg_rd) && $past(reg_addr) == 16'h4024
      |-> reg_rdata == $past(alo_r)) else $error("alarm low readback");
  chk_irq_single:
    assert property (alarm_irq |=> !alarm_irq)
    else $error("alarm event longer than one cycle");
  chk_irq_enabled:
    assert property (alarm_irq |-> $past(en_r))
    else $error("alarm event while disabled");
  chk_req_with_irq:
    assert property (wake_req || on_req |-> alarm_irq)
    else $error("power request without alarm");
  chk_wake_sleep:
    assert property (alarm_irq && pwr_sleep && $past(pwr_sleep)
      |-> wake_req && !on_req) else $error("no wake request in sleep");
  chk_on_off:
    assert property (alarm_irq && pwr_off && $past(pwr_off) && !pwr_sleep
      && !$past(pwr_sleep) |-> on_req && !wake_req)
    else $error("no power-on request in off");
  chk_awake_quiet:
    assert property (alarm_irq && !pwr_off && !$past(pwr_off) && !pwr_sleep
      && !$past(pwr_sleep) |-> !on_req && !wake_req)
    else $error("power request while active");
endmodule
bind srt_rtc srt_rtc_chk u_chk (.core_clk(core_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwr_sleep(pwr_sleep),
  .pwr_off(pwr_off), .alarm_irq(alarm_irq), .wake_req(wake_req),
  .on_req(on_req));

/* File: testbench/srt_rtc_tb_top.sv */
`timescale 1ns/1ns
module srt_rtc_tb_top;
  localparam logic [15:0] KEY = 16'h5A5A;
  logic core_clk, reset, xtal_in, reg_wr, reg_rd, pwr_sleep, pwr_off;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, v, t0;
  logic alarm_irq, wake_req, on_req;
  int err_count = 0, compares = 0, cyc = 0, irq_n = 0, wk_n = 0, on_n = 0;
  srt_rtc #(.UNLOCK_CODE(KEY)) u_dut (.core_clk(core_clk), .reset(reset),
    .xtal_in(xtal_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pwr_sleep(pwr_sleep), .pwr_off(pwr_off), .alarm_irq(alarm_irq),
    .wake_req(wake_req), .on_req(on_req));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // fast stand-in oscillator so sync-busy clears quickly
  initial begin
    xtal_in = 1'b0;
    forever #40 xtal_in = ~xtal_in;
  end
  always @(posedge core_clk) begin
    cyc++;
    irq_n += (alarm_irq === 1'b1);
    wk_n += (wake_req === 1'b1);
    on_n += (on_req === 1'b1);
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  task results();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task rchk(input logic [15:0] a, input logic [15:0] e);
    rd(a, v);
    chk(v, e);
  endtask
  // host side: poll busy, up to 60 reads, before writing clock registers
  task cwr(input logic [15:0] a, input logic [15:0] d);
    for (int i = 0; i < 60; i++) begin
      rd(16'h4025, v);
      if (v[2] === 1'b0) break;
    end
    chk({15'h0, v[2]}, 16'h0000);
    wr(a, d);
  endtask
  task alarm_try(input logic [15:0] lo, input int ei, ew, eo);
    int i0, w0, o0;
    i0 = irq_n;
    w0 = wk_n;
    o0 = on_n;
    cwr(16'h4022, lo);
    repeat (4) @(posedge core_clk);
    chk(16'(irq_n - i0), 16'(ei));
    chk(16'(wk_n - w0), 16'(ew));
    chk(16'(on_n - o0), 16'(eo));
  endtask
  initial begin
    {reset, reg_wr, reg_rd, pwr_sleep, pwr_off} = 5'b10000;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    for (int a = 0; a < 6; a++) rchk(16'h4020 + 16'(a), 16'h0000);
    $display("test reset values done");
    cwr(16'h4023, 16'h0000);
    cwr(16'h4024, 16'h0010);
    cwr(16'h4025, 16'h0001);
    rchk(16'h4024, 16'h0010);
    pwr_sleep <= 1'b1;
    rd(16'h4020, t0);
    cwr(16'h4021, 16'h0000);
    rchk(16'h4025, 16'h0007);
    rd(16'h4020, v);
    chk({15'h0, v !== t0}, 16'h0001);
    alarm_try(16'h0010, 1, 1, 0);
    rchk(16'h4022, 16'h0010);
    pwr_sleep <= 1'b0;
    pwr_off <= 1'b1;
    alarm_try(16'h0011, 0, 0, 0);
    alarm_try(16'h0010, 1, 0, 1);
    pwr_off <= 1'b0;
    alarm_try(16'h0011, 0, 0, 0);
    alarm_try(16'h0010, 1, 0, 0);
    cwr(16'h4025, 16'h0000);
    alarm_try(16'h0011, 0, 0, 0);
    alarm_try(16'h0010, 0, 0, 0);
    $display("test alarm done");
    rd(16'h4020, t0);
    cwr(16'h4022, 16'h00AA);
    rchk(16'h4022, 16'h0010);
    rchk(16'h4025, 16'h0002);
    rchk(16'h4020, t0);
    wr(16'h4020, 16'h1234);
    wr(16'h4030, 16'hFFFF);
    rchk(16'h4020, t0);
    rchk(16'h4024, 16'h0010);
    $display("test update limit done");
    wr(16'h4026, 16'h0040);
    rchk(16'h4026, 16'h0000);
    wr(16'h4027, KEY);
    rchk(16'h4027, 16'h0001);
    cwr(16'h4026, 16'h02F2);
    rchk(16'h4026, 16'h02F2);
    wr(16'h4027, 16'h0000);
    cwr(16'h4026, 16'h0000);
    rchk(16'h4026, 16'h02F2);
    $display("test trim lock done");
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rchk(16'h4020, 16'h0000);
    rchk(16'h4022, 16'h0000);
    rchk(16'h4026, 16'h0000);
    rchk(16'h4027, 16'h0000);
    rchk(16'h4025, 16'h0000);
    cwr(16'h4021, 16'h0123);
    rchk(16'h4025, 16'h0006);
    rchk(16'h4021, 16'h0123);
    $display("test second reset done");
    results();
  end
endmodule
